// *** design/otpisp_array.sv ***
/*
 * One-time-programmable array model as flip-flop storage: code fetch port,
 * verify read port, AND-only programming and a read-only signature space.
 * Assumes the caller holds prog_en_i only while a programming pulse runs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "otpisp_defs.svh"

module otpisp_array #(
   parameter int ADDR_W = 13,
   parameter int DEPTH = 8192,
   parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
   parameter logic [7:0] SIG_BYTE1 = 8'ha5, // arbitrary value
   parameter logic [7:0] SIG_BYTE2 = 8'h00  // arbitrary value
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // programming and verify port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic prog_en_i,
   input wire logic sig_i,
   output logic [7:0] rdata_o,
   // code fetch port
   input wire logic [ADDR_W-1:0] fetch_addr_i,
   output logic [7:0] fetch_data_o
);

   logic [7:0] mem_q [DEPTH];
   logic [7:0] rdata_d;
   logic [7:0] cell_d;
   logic [7:0] fetch_d;

   // signature lookup, zero outside the three bytes
   function automatic logic [7:0] sig_byte(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(`OTPISP_SIG_ADR0)) begin
         return SIG_BYTE0;
      end else if (a == ADDR_W'(`OTPISP_SIG_ADR1)) begin
         return SIG_BYTE1;
      end else if (a == ADDR_W'(`OTPISP_SIG_ADR2)) begin
         return SIG_BYTE2;
      end
      return `OTPISP_RST_BYTE;
   endfunction : sig_byte

   // next values: bits can only go from one to zero
   always_comb begin
      cell_d = mem_q[addr_i] & wdata_i;
      rdata_d = sig_i ? sig_byte(addr_i) : mem_q[addr_i];
      fetch_d = mem_q[fetch_addr_i];
   end

   // storage, blank after reset; signature space is never written
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= `OTPISP_BLANK_BYTE;
         end
         rdata_o <= `OTPISP_RST_BYTE;
         fetch_data_o <= `OTPISP_RST_BYTE;
      end else begin
         if (prog_en_i && !sig_i) begin
            mem_q[addr_i] <= cell_d;
         end
         rdata_o <= rdata_d;
         fetch_data_o <= fetch_d;
      end
   end

endmodule : otpisp_array

`default_nettype wire

// *** design/otpisp_defs.svh ***
/*
 * Constants for the in-system OTP programming block: special function
 * register addresses, control bit positions, reset values and the
 * signature space addresses.
 * Assumes an 8-bit special function register bus with 8-bit addresses.
 */
`ifndef OTPISP_DEFS_SVH
`define OTPISP_DEFS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define OTPISP_ADR_CTRL 8'hdc
`define OTPISP_ADR_DATA 8'hd9
`define OTPISP_ADR_AHI 8'hda
`define OTPISP_ADR_ALO 8'hdb
`define OTPISP_ADR_TEST 8'hdd

// ----------------------------------------------------------------------
// control and test register bits
// ----------------------------------------------------------------------
`define OTPISP_BIT_MODE 0
`define OTPISP_BIT_WE 1
`define OTPISP_BIT_SIG 2
`define OTPISP_BIT_HV 4
`define OTPISP_BIT_DCRD 3

// ----------------------------------------------------------------------
// reset values and array constants
// ----------------------------------------------------------------------
`define OTPISP_RST_BYTE 8'h00
`define OTPISP_BLANK_BYTE 8'hff
`define OTPISP_AHI_BITS 5
`define OTPISP_SIG_ADR0 13'h0030
`define OTPISP_SIG_ADR1 13'h0031
`define OTPISP_SIG_ADR2 13'h0060

`endif

// *** design/otpisp_pkg.sv ***
/*
 * Types shared by the in-system OTP programming block.
 * Assumes otpisp_defs.svh is on the include path.
 */
package otpisp_pkg;

   // ----------------------------------------------------------------------
   // sequencer states, gray coded along run -> prog and read -> hold -> run; run -> read flips both bits
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      OTPISP_RUN = 2'b00,
      OTPISP_PROG = 2'b01,
      OTPISP_READ = 2'b11,
      OTPISP_HOLD = 2'b10
   } otpisp_state_t;

endpackage : otpisp_pkg

// *** design/otpisp_top.sv ***
/*
 * In-system OTP programming controller: address, data, control and array
 * test registers on the special function register bus, an idle-driven
 * program and verify sequencer, and the array itself.
 * Assumes the core signals idle as a level and a timer ends idle; the high
 * voltage detector and the I2C address match arrive as synchronous levels.
 */
`timescale 1ns/1ps
`default_nettype none
`include "otpisp_defs.svh"

// Behaviour
// - reprogramming a byte leaves the AND of old and new data.
// - three read-only signature bytes at 030H, 031H, 060H, separate space.
// - control bit 0 enters in-system programming mode and reads back as status.
// - control bit 4 is read-only, showing programming high voltage presence.
// - I2C address match raises interrupt; software checks high-voltage flag.
// - programming pulse lasts while core idles; fetching resumes after idle.
// - idle with write enable clear starts verify read into data register.
// - bit 2 selects signature reads; signature contents never change.
// - bit 1 write enable gates any programming pulse to the array.
// - control bits 7 to 5 and 3 are reserved, no function.
// - programmed byte comes from data register, address from address pair.
// - high voltage on the reset-enable pin forces power-on reset enabled.
// - mode bit enables the idle program and verify sequencer and blocks transparent mode.
module otpisp_top
   import otpisp_pkg::*;
#(
   parameter int ADDR_W = 13,
   parameter int DEPTH = 8192
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // special function register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // core and pins
   input wire logic cpu_idle_i,
   input wire logic high_voltage_present_i,
   input wire logic reset_circuit_enable_pin_i,
   input wire logic i2c_addressed_i,
   input wire logic transparent_req_i,
   // code fetch
   input wire logic [ADDR_W-1:0] fetch_addr_i,
   output logic [7:0] fetch_data_o,
   output logic fetch_ready_o,
   // status outputs
   output logic prog_pulse_o,
   output logic i2c_irq_o,
   output logic por_enable_o,
   output logic transparent_active_o,
   output logic dc_read_mode_o
);

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [7:0] prog_data_reg_q, prog_data_reg_d;
   logic [7:0] prog_address_high_q, prog_address_high_d;
   logic [7:0] prog_address_low_q, prog_address_low_d;
   logic [7:0] array_test_reg_q, array_test_reg_d;
   logic in_system_prog_active_q, in_system_prog_active_d;
   logic write_enable_q, write_enable_d;
   logic signature_space_select_q, signature_space_select_d;
   logic [7:0] sfr_rdata_d;
   otpisp_state_t state_q, state_d;
   logic idle_q;
   logic prog_pulse_d, fetch_ready_d, i2c_irq_d, por_enable_d, transp_d;
   logic [7:0] array_rdata;
   logic [ADDR_W-1:0] array_addr;
   logic [7:0] insys_control_reg;
   logic idle_rise;

   function automatic logic is_wr(input logic [7:0] a, input logic [7:0] target,
                                  input logic wr);
      return wr && (a == target);
   endfunction : is_wr

   // address pair and read view of the control register
   assign array_addr = {prog_address_high_q[`OTPISP_AHI_BITS-1:0],
                        prog_address_low_q};
   assign insys_control_reg = {3'h0, high_voltage_present_i, 1'b0,
                               signature_space_select_q, write_enable_q,
                               in_system_prog_active_q};
   assign idle_rise = cpu_idle_i && !idle_q;

   // ----------------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------------
   always_comb begin
      prog_data_reg_d = prog_data_reg_q;
      prog_address_high_d = prog_address_high_q;
      prog_address_low_d = prog_address_low_q;
      array_test_reg_d = array_test_reg_q;
      in_system_prog_active_d = in_system_prog_active_q;
      write_enable_d = write_enable_q;
      signature_space_select_d = signature_space_select_q;
      if (is_wr(sfr_addr_i, `OTPISP_ADR_DATA, sfr_wr_i)) begin
         prog_data_reg_d = sfr_wdata_i;
      end
      if (is_wr(sfr_addr_i, `OTPISP_ADR_AHI, sfr_wr_i)) begin
         prog_address_high_d = sfr_wdata_i;
      end
      if (is_wr(sfr_addr_i, `OTPISP_ADR_ALO, sfr_wr_i)) begin
         prog_address_low_d = sfr_wdata_i;
      end
      if (is_wr(sfr_addr_i, `OTPISP_ADR_TEST, sfr_wr_i)) begin
         array_test_reg_d = sfr_wdata_i;
      end
      if (is_wr(sfr_addr_i, `OTPISP_ADR_CTRL, sfr_wr_i)) begin
         in_system_prog_active_d = sfr_wdata_i[`OTPISP_BIT_MODE];
         write_enable_d = sfr_wdata_i[`OTPISP_BIT_WE];
         signature_space_select_d = sfr_wdata_i[`OTPISP_BIT_SIG];
      end
      // verify latch wins over a same-cycle software write
      if (state_q == OTPISP_READ) begin
         prog_data_reg_d = array_rdata;
      end
      // read decode
      if (!sfr_rd_i) begin
         sfr_rdata_d = sfr_rdata_o;
      end else if (sfr_addr_i == `OTPISP_ADR_CTRL) begin
         sfr_rdata_d = insys_control_reg;
      end else if (sfr_addr_i == `OTPISP_ADR_DATA) begin
         sfr_rdata_d = prog_data_reg_q;
      end else if (sfr_addr_i == `OTPISP_ADR_AHI) begin
         sfr_rdata_d = prog_address_high_q;
      end else if (sfr_addr_i == `OTPISP_ADR_ALO) begin
         sfr_rdata_d = prog_address_low_q;
      end else if (sfr_addr_i == `OTPISP_ADR_TEST) begin
         sfr_rdata_d = array_test_reg_q;
      end else begin
         sfr_rdata_d = `OTPISP_RST_BYTE;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prog_data_reg_q <= `OTPISP_RST_BYTE;
         prog_address_high_q <= `OTPISP_RST_BYTE;
         prog_address_low_q <= `OTPISP_RST_BYTE;
         array_test_reg_q <= `OTPISP_RST_BYTE;
         in_system_prog_active_q <= 1'b0;
         write_enable_q <= 1'b0;
         signature_space_select_q <= 1'b0;
         sfr_rdata_o <= `OTPISP_RST_BYTE;
      end else begin
         prog_data_reg_q <= prog_data_reg_d;
         prog_address_high_q <= prog_address_high_d;
         prog_address_low_q <= prog_address_low_d;
         array_test_reg_q <= array_test_reg_d;
         in_system_prog_active_q <= in_system_prog_active_d;
         write_enable_q <= write_enable_d;
         signature_space_select_q <= signature_space_select_d;
         sfr_rdata_o <= sfr_rdata_d;
      end
   end

   // ----------------------------------------------------------------------
   // idle-driven program and verify sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         OTPISP_RUN: begin
            if (idle_rise && in_system_prog_active_q) begin
               if (write_enable_q && !signature_space_select_q
                   && high_voltage_present_i) begin
                  state_d = OTPISP_PROG;
               end else if (!write_enable_q) begin
                  state_d = OTPISP_READ;
               end
            end
         end
         OTPISP_PROG: begin
            if (!cpu_idle_i) begin
               state_d = OTPISP_RUN;
            end
         end
         OTPISP_READ: begin
            state_d = OTPISP_HOLD;
         end
         default: begin
            if (!cpu_idle_i) begin
               state_d = OTPISP_RUN;
            end
         end
      endcase
      prog_pulse_d = (state_d == OTPISP_PROG);
      fetch_ready_d = (state_d == OTPISP_RUN);
      i2c_irq_d = i2c_addressed_i;
      por_enable_d = reset_circuit_enable_pin_i || high_voltage_present_i;
      transp_d = transparent_req_i && !in_system_prog_active_q;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= OTPISP_RUN;
         idle_q <= 1'b0;
         prog_pulse_o <= 1'b0;
         fetch_ready_o <= 1'b0;
         i2c_irq_o <= 1'b0;
         por_enable_o <= 1'b0;
         transparent_active_o <= 1'b0;
         dc_read_mode_o <= 1'b0;
      end else begin
         state_q <= state_d;
         idle_q <= cpu_idle_i;
         prog_pulse_o <= prog_pulse_d;
         fetch_ready_o <= fetch_ready_d;
         i2c_irq_o <= i2c_irq_d;
         por_enable_o <= por_enable_d;
         transparent_active_o <= transp_d;
         dc_read_mode_o <= array_test_reg_q[`OTPISP_BIT_DCRD];
      end
   end

   // ----------------------------------------------------------------------
   // array
   // ----------------------------------------------------------------------
   otpisp_array #(
      .ADDR_W(ADDR_W),
      .DEPTH(DEPTH)
   ) u_array (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .addr_i(array_addr),
      .wdata_i(prog_data_reg_q),
      .prog_en_i(prog_pulse_o),
      .sig_i(signature_space_select_q),
      .rdata_o(array_rdata),
      .fetch_addr_i(fetch_addr_i),
      .fetch_data_o(fetch_data_o)
   );

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   AST_PULSE_NEEDS_WE: assert property (prog_pulse_o |-> write_enable_q)
      else $error("program pulse without write enable");
   AST_PULSE_NO_SIG: assert property (prog_pulse_o |-> !signature_space_select_q)
      else $error("program pulse in signature space");
   AST_PULSE_ENDS: assert property (prog_pulse_o && !cpu_idle_i |=> !prog_pulse_o)
      else $error("program pulse outlived idle");
   AST_PULSE_STARTS: assert property (state_q == OTPISP_RUN && cpu_idle_i && !idle_q
      && in_system_prog_active_q && write_enable_q && !signature_space_select_q
      && high_voltage_present_i |=> prog_pulse_o)
      else $error("program pulse did not start");
   AST_VERIFY_LATCH: assert property (state_q == OTPISP_RUN && cpu_idle_i && !idle_q
      && in_system_prog_active_q && !write_enable_q |=> ##1
      prog_data_reg_q == $past(array_rdata))
      else $error("verify data not latched");
   AST_HV_FLAG: assert property (sfr_rd_i && sfr_addr_i == `OTPISP_ADR_CTRL |=>
      sfr_rdata_o[`OTPISP_BIT_HV] == $past(high_voltage_present_i))
      else $error("high voltage flag wrong");
   AST_RESERVED: assert property (sfr_rd_i && sfr_addr_i == `OTPISP_ADR_CTRL |=>
      sfr_rdata_o[7:5] == 3'h0 && !sfr_rdata_o[`OTPISP_BIT_DCRD])
      else $error("reserved control bits not zero");
   AST_MODE_BIT: assert property (is_wr(sfr_addr_i, `OTPISP_ADR_CTRL, sfr_wr_i) |=>
      in_system_prog_active_q == $past(sfr_wdata_i[`OTPISP_BIT_MODE]))
      else $error("mode bit not written");
   AST_POR_FORCE: assert property (high_voltage_present_i |=> por_enable_o)
      else $error("power-on reset not forced");
   AST_TRANSP: assert property (in_system_prog_active_q |=> !transparent_active_o)
      else $error("transparent mode not suppressed");
   AST_IRQ: assert property (i2c_addressed_i |=> i2c_irq_o)
      else $error("address match interrupt missing");
   AST_ADDR_REG: assert property (is_wr(sfr_addr_i, `OTPISP_ADR_ALO, sfr_wr_i) |=>
      array_addr[7:0] == $past(sfr_wdata_i))
      else $error("low address not applied");

   COV_PROG: cover property (prog_pulse_o ##1 !prog_pulse_o);
   COV_VERIFY: cover property (state_q == OTPISP_READ ##1 state_q == OTPISP_HOLD);
   COV_SIG_READ: cover property (signature_space_select_q && state_q == OTPISP_READ);

endmodule : otpisp_top

`default_nettype wire

// *** verif/otp_in_system_programming_bench.sv ***
/*
 * Self-checking bench for the in-system OTP programming controller:
 * register table, program, verify, signature and pin-level checks.
 * Assumes otpisp_defs.svh on the include path and array signature defaults.
 */
`timescale 1ns/1ps
`default_nettype none
`include "otpisp_defs.svh"

module otp_in_system_programming_bench;
   // ----------------------------------------------------------------------
   // signals and bookkeeping
   // ----------------------------------------------------------------------
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   logic sfr_rd_i = 1'b0;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] sfr_rdata_o;
   logic cpu_idle_i = 1'b0;
   logic transparent_req_i = 1'b0;
   logic [12:0] fetch_addr_i = 13'h0000;
   logic [7:0] fetch_data_o;
   logic fetch_ready_o, prog_pulse_o, i2c_irq_o, por_enable_o;
   logic transparent_active_o, dc_read_mode_o;
   logic hv_req = 1'b0, addr_req = 1'b0, pin_lvl = 1'b0;
   logic hv, hv_ready, i2c_addr, pin;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   int k;
   logic [23:0] rows [5];
   logic [7:0] sig_adr [3] = '{8'h30, 8'h31, 8'h60};
   logic [7:0] sig_val [3] = '{8'h5a, 8'ha5, 8'h00}; // arbitrary array defaults

   // clock of 20 ns period
   always #10 mclk_i = ~mclk_i;

   // ----------------------------------------------------------------------
   // design and partner
   // ----------------------------------------------------------------------
   otpisp_top #(.ADDR_W(13), .DEPTH(8192)) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i),
      .high_voltage_present_i(hv), .reset_circuit_enable_pin_i(pin),
      .i2c_addressed_i(i2c_addr), .transparent_req_i(transparent_req_i),
      .fetch_addr_i(fetch_addr_i), .fetch_data_o(fetch_data_o),
      .fetch_ready_o(fetch_ready_o), .prog_pulse_o(prog_pulse_o),
      .i2c_irq_o(i2c_irq_o), .por_enable_o(por_enable_o),
      .transparent_active_o(transparent_active_o), .dc_read_mode_o(dc_read_mode_o));

   otpisp_hv_master #(.SETUP_CYC(500)) master (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hv_req_i(hv_req), .addr_req_i(addr_req),
      .pin_lvl_i(pin_lvl), .hv_o(hv), .hv_ready_o(hv_ready), .i2c_addr_o(i2c_addr),
      .pin_o(pin));

   // ----------------------------------------------------------------------
   // helper tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge mclk_i);
      sfr_wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge mclk_i);
      sfr_rd_i <= 1'b0;
      #1 chk(sfr_rdata_o, e);
   endtask : rd

   // idle window: pulse and ready inside, both restored after
   task automatic run_idle(input logic pe, input logic re);
      @(posedge mclk_i) cpu_idle_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      #1 chk({7'h0, prog_pulse_o}, {7'h0, pe});
      chk({7'h0, fetch_ready_o}, {7'h0, re});
      @(posedge mclk_i) cpu_idle_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1 chk({7'h0, prog_pulse_o}, 8'h00);
      chk({7'h0, fetch_ready_o}, 8'h01);
   endtask : run_idle

   task automatic settle();
      repeat (3) @(posedge mclk_i);
      #1;
   endtask : settle

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   // hang guard
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rows = '{{`OTPISP_ADR_DATA, 8'ha5, 8'ha5}, {`OTPISP_ADR_AHI, 8'h3c, 8'h3c},
               {`OTPISP_ADR_ALO, 8'hc3, 8'hc3}, {`OTPISP_ADR_CTRL, 8'hff, 8'h07},
               {8'he0, 8'h55, 8'h00}};
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(`OTPISP_ADR_DATA, 8'h00);
      rd(`OTPISP_ADR_AHI, 8'h00);
      rd(`OTPISP_ADR_ALO, 8'h00);
      chk(fetch_data_o, `OTPISP_BLANK_BYTE);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      wr(`OTPISP_ADR_CTRL, 8'h00);
      $display("test registers done");
      // program twice, then verify and fetch
      @(posedge mclk_i) hv_req <= 1'b1;
      k = 0;
      while (hv_ready !== 1'b1 && k < 1000) begin
         @(posedge mclk_i);
         k++;
      end
      chk({7'h0, hv_ready}, 8'h01);
      wr(`OTPISP_ADR_TEST, 8'h08);
      settle();
      chk({7'h0, dc_read_mode_o}, 8'h01);
      wr(`OTPISP_ADR_CTRL, 8'h03);
      rd(`OTPISP_ADR_CTRL, 8'h13);
      wr(`OTPISP_ADR_AHI, 8'h01);
      wr(`OTPISP_ADR_ALO, 8'h23);
      wr(`OTPISP_ADR_DATA, 8'h5a);
      run_idle(1'b1, 1'b0);
      wr(`OTPISP_ADR_DATA, 8'h0f);
      run_idle(1'b1, 1'b0);
      wr(`OTPISP_ADR_CTRL, 8'h01);
      wr(`OTPISP_ADR_DATA, 8'hff);
      run_idle(1'b0, 1'b0);
      rd(`OTPISP_ADR_DATA, 8'h0a);
      @(posedge mclk_i) fetch_addr_i <= 13'h0123;
      settle();
      chk(fetch_data_o, 8'h0a);
      $display("test program done");
      // forbidden write pulse in signature space, then signature reads
      wr(`OTPISP_ADR_AHI, 8'h00);
      wr(`OTPISP_ADR_ALO, 8'h30);
      wr(`OTPISP_ADR_DATA, 8'h00);
      wr(`OTPISP_ADR_CTRL, 8'h07);
      run_idle(1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         wr(`OTPISP_ADR_ALO, sig_adr[i]);
         wr(`OTPISP_ADR_CTRL, 8'h05);
         wr(`OTPISP_ADR_DATA, 8'hff);
         run_idle(1'b0, 1'b0);
         rd(`OTPISP_ADR_DATA, sig_val[i]);
      end
      wr(`OTPISP_ADR_ALO, 8'h30);
      wr(`OTPISP_ADR_CTRL, 8'h01);
      run_idle(1'b0, 1'b0);
      rd(`OTPISP_ADR_DATA, 8'hff);
      $display("test signature done");
      // leave programming, then no pulse without high voltage
      wr(`OTPISP_ADR_TEST, 8'h00);
      wr(`OTPISP_ADR_CTRL, 8'h00);
      @(posedge mclk_i) hv_req <= 1'b0;
      settle();
      chk({7'h0, dc_read_mode_o}, 8'h00);
      wr(`OTPISP_ADR_CTRL, 8'h03);
      run_idle(1'b0, 1'b1);
      rd(`OTPISP_ADR_CTRL, 8'h03);
      wr(`OTPISP_ADR_CTRL, 8'h00);
      $display("test refusal done");
      // pin-level paths
      chk({7'h0, por_enable_o}, 8'h00);
      @(posedge mclk_i) hv_req <= 1'b1;
      addr_req <= 1'b1;
      settle();
      chk({7'h0, por_enable_o}, 8'h01);
      chk({7'h0, i2c_irq_o}, 8'h01);
      @(posedge mclk_i) addr_req <= 1'b0;
      hv_req <= 1'b0;
      pin_lvl <= 1'b1;
      settle();
      chk({7'h0, i2c_irq_o}, 8'h00);
      chk({7'h0, por_enable_o}, 8'h01);
      wr(`OTPISP_ADR_CTRL, 8'h00);
      @(posedge mclk_i) transparent_req_i <= 1'b1;
      settle();
      chk({7'h0, transparent_active_o}, 8'h01);
      wr(`OTPISP_ADR_CTRL, 8'h01);
      settle();
      chk({7'h0, transparent_active_o}, 8'h00);
      $display("test pins done");
      finish_test();
   end

endmodule : otp_in_system_programming_bench
`default_nettype wire

// *** verif/otpisp_hv_master.sv ***
/*
 * Partner model of the external programming master: drives the programming
 * high voltage, the I2C address match and the reset-enable pin level.
 * Assumes the bench requests each level at the rising edge of mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module otpisp_hv_master #(
   parameter int SETUP_CYC = 500
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // requests from the bench
   input wire logic hv_req_i,
   input wire logic addr_req_i,
   input wire logic pin_lvl_i,
   // levels towards the device and ready flag to the bench
   output logic hv_o,
   output logic hv_ready_o,
   output logic i2c_addr_o,
   output logic pin_o
);
   int settle_q;

   // ----------------------------------------------------------------------
   // high voltage held steady and settle time counted before use
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hv_o <= 1'b0;
         settle_q <= 0;
         i2c_addr_o <= 1'b0;
         pin_o <= 1'b0;
      end else begin
         hv_o <= hv_req_i;
         settle_q <= hv_o ? settle_q + 1 : 0;
         i2c_addr_o <= addr_req_i;
         pin_o <= pin_lvl_i;
      end
   end

   // ready once the 10 us settle time has run at 50 MHz
   assign hv_ready_o = (settle_q >= SETUP_CYC);

endmodule : otpisp_hv_master
`default_nettype wire
